/* hdl/acs_pkg.sv */
// package: offsets, field layout and types for the compute status block
package acs_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [11:0] ACS_OFF_STATUS = 12'h000;
  localparam logic [11:0] ACS_OFF_EVENT  = 12'h004;
  localparam logic [11:0] ACS_OFF_MASK   = 12'h008;

  // ==========================================================
  // status field positions
  localparam int ACS_BIT_OVF   = 7;
  localparam int ACS_BIT_UPPER = 6;
  localparam int ACS_BIT_LOWER = 5;
  localparam int ACS_BIT_UPD   = 4;
  localparam int ACS_BIT_RSVD  = 3;
  localparam int ACS_STAGE_LSB = 0;

  // event bits
  localparam int ACS_EV_UPD   = 0;
  localparam int ACS_EV_OVF   = 1;
  localparam int ACS_EV_UPPER = 2;
  localparam int ACS_EV_LOWER = 3;
  localparam int ACS_EV_W     = 4;

  localparam logic [ACS_EV_W-1:0] ACS_EV_RESET = 4'h0;

  // ==========================================================
  // sequencer stage codes
  localparam logic [2:0] ACS_STG_IDLE   = 3'h0;
  localparam logic [2:0] ACS_STG_PRE1   = 3'h1;
  localparam logic [2:0] ACS_STG_ACQ1   = 3'h2;
  localparam logic [2:0] ACS_STG_CONV1  = 3'h3;
  localparam logic [2:0] ACS_STG_UNUSED = 3'h4;
  localparam logic [2:0] ACS_STG_PRE2   = 3'h5;
  localparam logic [2:0] ACS_STG_ACQ2   = 3'h6;
  localparam logic [2:0] ACS_STG_CONV2  = 3'h7;

  // one-hot phase of the sequencer as reported by the datapath
  typedef enum logic [2:0] {
    ACS_PH_PRE  = 3'b001,
    ACS_PH_ACQ  = 3'b010,
    ACS_PH_CONV = 3'b100
  } acs_phase_e;

  // sequencer report carried from the conversion sequencer
  typedef struct packed {
    logic       busy;
    logic       second;
    acs_phase_e phase;
  } acs_seq_s;

  // computation update strobes from the datapath
  typedef struct packed {
    logic acc_wr;
    logic fltr_wr;
    logic uth_wr;
    logic lth_wr;
    logic ovf_wr;
    logic acc_ovf;
    logic err_ovf;
  } acs_upd_s;

endpackage

/* hdl/acs_stage_enc.sv */
// stage code encoder: sequencer report to 3-bit stage field
module acs_stage_enc
  import acs_pkg::*;
(
  // sequencer report
  input  acs_pkg::acs_seq_s seq,
  // encoded stage
  output logic [2:0]        code
);

  always_comb begin
    code = ACS_STG_IDLE;                         // [RL6]
    if (seq.busy) begin
      unique case (seq.phase)
        ACS_PH_PRE:  code = seq.second ? ACS_STG_PRE2 : ACS_STG_PRE1;   // [RL5]
        ACS_PH_ACQ:  code = seq.second ? ACS_STG_ACQ2 : ACS_STG_ACQ1;   // [RL5]
        ACS_PH_CONV: code = seq.second ? ACS_STG_CONV2 : ACS_STG_CONV1; // [RL5]
        // illegal phase: report idle, never the unused code
        default:     code = ACS_STG_IDLE;         // [RL6]
      endcase
    end
  end

endmodule

/* hdl/acs_status.sv */
// compute status register with APB slave and event interrupt
//
// Contract
// [RL1] threshold flags follow error value comparisons
// [RL2] update flag sets on any computation update
// [RL3] update flag low only when nothing changed
// [RL4] bit three reads zero, holds nothing
// [RL5] stage field encodes pass and step
// [RL6] stage zero when idle; never code 100
// [RL7] overflow flag on accumulator or error overflow
// [RL8] software clears update flag writing zero
//
// Chosen here: the placing of the registers and register access over APB.
module acs_status
  import acs_pkg::*;
#(
  parameter int ERR_W = 16
) (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // computation datapath
  input  wire logic signed [ERR_W-1:0]   error_value,
  input  wire logic signed [ERR_W-1:0]   upper_limit,
  input  wire logic signed [ERR_W-1:0]   lower_limit,
  input  wire acs_pkg::acs_upd_s         upd,
  input  wire acs_pkg::acs_seq_s         seq,
  // status out
  output logic      [7:0]                status,
  output logic                           irq
);
  import acs_pkg::*;

  initial begin
    if (ERR_W < 2 || ERR_W > 32) $error("acs_status: ERR_W out of range");
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic                 compute_overflow_flag;
    logic                 above_upper_limit_flag;
    logic                 below_lower_limit_flag;
    logic                 compute_update_flag;
    logic [2:0]           sequencer_stage_code;
    logic [ACS_EV_W-1:0]  event_status;
    logic [ACS_EV_W-1:0]  event_mask;
    logic [31:0]          rdata;
  } acs_state_s;

  acs_state_s r;
  acs_state_s next_r;
  logic [2:0] stage_now;

  acs_stage_enc acs_stage_enc_inst (
    .seq  (seq),
    .code (stage_now)
  );

  // ==========================================================
  // bus decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  logic       acc_phase;
  logic       wr_acc;
  logic       rd_acc;
  logic       mapped;
  logic       any_upd;
  logic       upper_now;
  logic       lower_now;
  logic       ovf_now;
  logic [7:0] stat_word;
  logic [ACS_EV_W-1:0] ev_set;

  assign acc_phase = psel && penable;
  assign wr_acc    = acc_phase && pwrite;
  assign rd_acc    = psel && !penable && !pwrite;
  assign mapped    = hit(paddr, ACS_OFF_STATUS) || hit(paddr, ACS_OFF_EVENT)
                   || hit(paddr, ACS_OFF_MASK);

  // ==========================================================
  // hardware conditions
  assign upper_now = error_value > upper_limit;                  // [RL1]
  assign lower_now = error_value < lower_limit;                  // [RL1]
  assign ovf_now   = upd.acc_ovf || upd.err_ovf;                 // [RL7]
  // any write of the associated registers or overflow bit
  assign any_upd   = upd.acc_wr || upd.fltr_wr || upd.uth_wr
                   || upd.lth_wr || upd.ovf_wr;                   // [RL2]

  always_comb begin
    stat_word                = 8'h00;                             // [RL4]
    stat_word[ACS_BIT_OVF]   = r.compute_overflow_flag;
    stat_word[ACS_BIT_UPPER] = r.above_upper_limit_flag;
    stat_word[ACS_BIT_LOWER] = r.below_lower_limit_flag;
    stat_word[ACS_BIT_UPD]   = r.compute_update_flag;
    stat_word[ACS_STAGE_LSB +: 3] = r.sequencer_stage_code;
  end

  always_comb begin
    ev_set               = ACS_EV_RESET;
    ev_set[ACS_EV_UPD]   = any_upd;
    ev_set[ACS_EV_OVF]   = ovf_now && !r.compute_overflow_flag;
    ev_set[ACS_EV_UPPER] = upper_now && !r.above_upper_limit_flag;
    ev_set[ACS_EV_LOWER] = lower_now && !r.below_lower_limit_flag;
  end

  // ==========================================================
  // next state
  always_comb begin
    next_r = r;
    next_r.compute_overflow_flag  = ovf_now;                      // [RL7]
    next_r.above_upper_limit_flag = upper_now;                    // [RL1]
    next_r.below_lower_limit_flag = lower_now;                    // [RL1]
    next_r.sequencer_stage_code   = stage_now;                    // [RL5] [RL6]

    // only the update flag is writable; zero clears, update wins over clear
    if (wr_acc && hit(paddr, ACS_OFF_STATUS) && pstrb[0]
        && !pwdata[ACS_BIT_UPD]) begin
      next_r.compute_update_flag = 1'b0;                          // [RL8]
    end
    if (any_upd) begin
      next_r.compute_update_flag = 1'b1;                          // [RL2] [RL3]
    end

    // sticky events: write one clears, new event wins
    if (wr_acc && hit(paddr, ACS_OFF_EVENT) && pstrb[0]) begin
      next_r.event_status = r.event_status & ~pwdata[ACS_EV_W-1:0];
    end
    next_r.event_status = next_r.event_status | ev_set;

    if (wr_acc && hit(paddr, ACS_OFF_MASK) && pstrb[0]) begin
      next_r.event_mask = pwdata[ACS_EV_W-1:0];
    end

    // read data captured in setup so it is stable through access
    if (rd_acc) begin
      next_r.rdata = 32'h0000_0000;
      if (hit(paddr, ACS_OFF_STATUS)) begin
        next_r.rdata[7:0] = stat_word;
      end else if (hit(paddr, ACS_OFF_EVENT)) begin
        next_r.rdata[ACS_EV_W-1:0] = r.event_status;
      end else if (hit(paddr, ACS_OFF_MASK)) begin
        next_r.rdata[ACS_EV_W-1:0] = r.event_mask;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs
  assign prdata  = r.rdata;
  assign pready  = 1'b1;
  assign pslverr = acc_phase && !mapped;
  assign status  = stat_word;
  assign irq     = |(r.event_status & r.event_mask);

endmodule

/* test/acs_status_properties.sv */
// checker: timing relations between inputs and the status byte
module acs_status_checker
  import acs_pkg::*;
#(
  parameter int ERR_W = 16
) (
  // clock and reset
  input wire logic                    pclk,
  input wire logic                    presetn,
  // apb
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [11:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [3:0]              pstrb,
  // datapath
  input wire logic signed [ERR_W-1:0] error_value,
  input wire logic signed [ERR_W-1:0] upper_limit,
  input wire logic signed [ERR_W-1:0] lower_limit,
  input wire acs_pkg::acs_upd_s       upd,
  input wire acs_pkg::acs_seq_s       seq,
  // status
  input wire logic [7:0]              status,
  input wire logic                    irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // any register write strobe from the datapath
  logic any_wr;
  assign any_wr = |upd[6:2];
  // first edge after release still sees reset values, hence past(presetn)
  property p_up;
    $past(presetn) |-> status[6] == ($past(error_value) > $past(upper_limit));
  endproperty
  a_up: assert property (p_up) else $error("upper flag");
  property p_lo;
    $past(presetn) |-> status[5] == ($past(error_value) < $past(lower_limit));
  endproperty
  a_lo: assert property (p_lo) else $error("lower flag");
  property p_ovf;
    $past(presetn) |-> status[7] == ($past(upd.acc_ovf) | $past(upd.err_ovf));
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag");
  property p_rsv; status[3] == 1'b0; endproperty
  a_rsv: assert property (p_rsv) else $error("bit three set");
  property p_nu; status[2:0] != ACS_STG_UNUSED; endproperty
  a_nu: assert property (p_nu) else $error("unused stage code");
  property p_idle;
    $past(presetn) && !$past(seq.busy) |-> status[2:0] == ACS_STG_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("stage not idle");
  property p_set; any_wr |=> status[4]; endproperty
  a_set: assert property (p_set) else $error("update not set");
  property p_hold; !status[4] && !any_wr |=> !status[4]; endproperty
  a_hold: assert property (p_hold) else $error("update set alone");
  property p_clr;
    psel && penable && pwrite && paddr == ACS_OFF_STATUS && pstrb[0] && !pwdata[4]
      && !any_wr |=> !status[4];
  endproperty
  a_clr: assert property (p_clr) else $error("update not cleared");
  c_set: cover property (any_wr ##1 status[4]);
  c_clr: cover property (status[4] ##1 !status[4]);
  c_irq: cover property ($rose(irq));
endmodule
bind acs_status acs_status_checker #(.ERR_W(ERR_W)) acs_status_checker_inst (.*);

/* test/test_adc_compute_status_flags.sv */
// testbench: flags, stage field, update clear and interrupt over apb
module test_adc_compute_status_flags;
  timeunit 1ns;
  timeprecision 1ps;
  import acs_pkg::*;
  logic               pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]        paddr = '0;
  logic [31:0]        pwdata = '0, prdata, r;
  logic [3:0]         pstrb = 4'hF;
  logic signed [15:0] ev = '0, ul = '0, ll = '0;
  acs_upd_s           upd = '0;
  acs_seq_s           seq = '0;
  logic [7:0]         status;
  logic               pready, pslverr, irq, e;
  int                 error_cnt = 0, checks = 0;
  always #5 pclk = ~pclk;
  acs_status #(.ERR_W(16)) acs_status_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .error_value(ev),
    .upper_limit(ul), .lower_limit(ll), .upd, .seq, .status, .irq);
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) begin
      chk(0, 1, "apb hang");
      results();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so a following call never re-drives psel in this step
      @(posedge pclk);
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_ovf();
    apb(1, ACS_OFF_MASK, 0);
    upd <= 7'h02;
    repeat (2) @(posedge pclk);
    chk(status[7], 1, "acc ovf");
    chk(irq, 0, "masked irq");
    upd <= 7'h01;
    repeat (2) @(posedge pclk);
    chk(status[7], 1, "err ovf");
    upd <= '0;
    repeat (2) @(posedge pclk);
    chk(status[7], 0, "no ovf");
    apb(0, ACS_OFF_EVENT, 0);
    chk(r, 32'h2, "ovf event");
    apb(0, 12'h00C, 0);
    chk(e, 1, "unmapped err");
    chk(r, 0, "unmapped data");
    $display("t_ovf done");
  endtask
  task automatic t_upd();
    apb(1, ACS_OFF_MASK, 32'h1);
    for (int k = 0; k < 5; k++) begin
      upd <= 7'h40 >> k;
      @(posedge pclk);
      upd <= '0;
      repeat (2) @(posedge pclk);
      chk(status[4], 1, "upd set");
      chk(irq, 1, "irq on");
      apb(1, ACS_OFF_STATUS, 0);
      apb(0, ACS_OFF_STATUS, 0);
      chk(r[4], 0, "upd clear");
      apb(1, ACS_OFF_EVENT, 32'h1);
      repeat (2) @(posedge pclk);
      chk(irq, 0, "irq off");
    end
    $display("t_upd done");
  endtask
  task automatic thr(input logic signed [15:0] e0, u0, l0, input logic [1:0] x);
    ev <= e0;
    ul <= u0;
    ll <= l0;
    repeat (2) @(posedge pclk);
    chk(status[6:5], x, "thresholds");
  endtask
  task automatic t_thr();
    thr(5, 5, 5, 2'b00);
    thr(6, 5, -3, 2'b10);
    thr(-3, 5, -3, 2'b00);
    thr(-32768, 32767, -32767, 2'b01);
    apb(0, ACS_OFF_STATUS, 0);
    chk(r, 32'h20, "status word");
    $display("t_thr done");
  endtask
  task automatic t_stage();
    logic [2:0] ph [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
    logic [3:0] x;
    for (int i = 0; i < 16; i++) begin
      seq <= {i[3], i[2], ph[i[1:0]]};
      x = (i[3] && i[1:0] != 2'd3) ? {1'b0, i[2], i[1:0] + 2'd1} : 4'h0;
      repeat (2) @(posedge pclk);
      chk(status[3:0], x, "stage");
    end
    $display("t_stage done");
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk(status, 0, "reset status");
    t_ovf();
    t_upd();
    t_thr();
    t_stage();
    results();
  end
endmodule
